// ==== hdl/swb_cfg.svh ====
`ifndef SWB_CFG_SVH
`define SWB_CFG_SVH

// ==========================================================
// Widths
`define SWB_DATA_W 8
`define SWB_ADDR_W 12
`define SWB_BANK_W 4

// ==========================================================
// Operand address windows
`define SWB_INDEX_LIMIT 8'h5F
`define SWB_ACCESS_LO_BANK 4'h0
`define SWB_ACCESS_HI_BANK 4'hF

// ==========================================================
// Flag vector field positions
`define SWB_FLAG_W 5
`define SWB_FLAG_C 0
`define SWB_FLAG_DC 1
`define SWB_FLAG_Z 2
`define SWB_FLAG_OV 3
`define SWB_FLAG_N 4

// ==========================================================
// Reset values
`define SWB_ACC_RST 8'h00
`define SWB_FLAGS_RST 5'h00

`endif

// ==== hdl/swb_pkg.sv ====
package swb_pkg;

    // ======================================================
    // Execution phases; read, process and write take one clock each, idle holds until start
    typedef enum logic [1:0]
    {
        SWB_IDLE = 2'b00,
        SWB_READ = 2'b01,
        SWB_PROC = 2'b10,
        SWB_WRITE = 2'b11
    } swb_phase_e;

endpackage

// ==== hdl/swb_subber.sv ====
// ==========================================================
// Borrow subtractor: minuend minus subtrahend minus inverted carry
module swb_subber
#(
    parameter int W = 8
)
(
    input wire logic [W-1:0] minuend,
    input wire logic [W-1:0] subtrahend,
    input wire logic carryIn,
    output logic [W-1:0] diff,
    output logic carryOut,
    output logic halfCarry,
    output logic overflow
);

    logic [W:0] fullSum;
    logic [4:0] lowSum;

    // Add the ones' complement so carry means no borrow
    assign fullSum = {1'b0, minuend} + {1'b0, ~subtrahend}
                   + {{W{1'b0}}, carryIn};
    assign lowSum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
                  + {4'h0, carryIn};
    assign diff = fullSum[W-1:0];
    assign carryOut = fullSum[W];
    assign halfCarry = lowSum[4];
    // Signed wrap: operands differ in sign and result sign flips
    assign overflow = (minuend[W-1] ^ subtrahend[W-1])
                    & (minuend[W-1] ^ fullSum[W-1]);

endmodule

// ==== hdl/swb_exec.sv ====
`include "swb_cfg.svh"

module swb_exec
#(
    parameter int BANK_W = `SWB_BANK_W
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [7:0] operandAddr,
    input wire logic resultTarget,
    input wire logic windowSelect,
    input wire logic extendedEnable,
    input wire logic [BANK_W-1:0] bankPointer,
    input wire logic [`SWB_ADDR_W-1:0] indexBase,
    input wire logic accLoad,
    input wire logic [7:0] accLoadValue,
    input wire logic flagsLoad,
    input wire logic [`SWB_FLAG_W-1:0] flagsLoadValue,
    input wire logic [7:0] memRdData,
    output logic [`SWB_ADDR_W-1:0] memAddr,
    output logic memRdEn,
    output logic memWrEn,
    output logic [7:0] memWrData,
    output logic [7:0] accumulator,
    output logic [`SWB_FLAG_W-1:0] flags,
    output logic busy,
    output logic done
);

    // ======================================================
    // State
    swb_pkg::swb_phase_e phase_q;
    swb_pkg::swb_phase_e phase_d;
    logic [`SWB_ADDR_W-1:0] addr_q;
    logic [7:0] opAddr_q;
    logic target_q;
    logic window_q;
    logic ext_q;
    logic [BANK_W-1:0] bank_q;
    logic [7:0] opnd_q;
    logic [7:0] result_q;
    logic [`SWB_FLAG_W-1:0] pend_q;
    logic [7:0] acc_q;
    logic [`SWB_FLAG_W-1:0] flags_q;

    logic takeStart;
    logic lowWindow;
    logic useIndexed;
    logic [`SWB_ADDR_W-1:0] accessAddr;
    logic [`SWB_ADDR_W-1:0] bankedAddr;
    logic [`SWB_ADDR_W-1:0] indexedAddr;
    logic [`SWB_ADDR_W-1:0] operandFullAddr;
    logic [7:0] diff;
    logic carryOut;
    logic halfCarry;
    logic overflow;
    logic [`SWB_FLAG_W-1:0] newFlags;
    logic commit;

    // ======================================================
    // Address formation, decided when the request is taken
    // Low part of the access window; also the indexed range
    function automatic logic in_low_window(input logic [7:0] a);
        in_low_window = (a <= `SWB_INDEX_LIMIT);
    endfunction

    assign takeStart = start && (phase_q == swb_pkg::SWB_IDLE);
    assign lowWindow = in_low_window(operandAddr);
    // Indexed mode only without the banked window
    assign useIndexed = !windowSelect && extendedEnable
                      && lowWindow;
    // Access bank: low part in bank zero, rest in top bank
    assign accessAddr = lowWindow
                      ? {`SWB_ACCESS_LO_BANK, operandAddr}
                      : {`SWB_ACCESS_HI_BANK, operandAddr};
    assign bankedAddr = {bankPointer, operandAddr};
    // Wraps in the data space; no range check on the index base
    assign indexedAddr = indexBase
                       + {{(`SWB_ADDR_W-8){1'b0}}, operandAddr};
    assign operandFullAddr = windowSelect ? bankedAddr
                           : (useIndexed ? indexedAddr
                           : accessAddr);

    // ======================================================
    // Arithmetic on the fetched operand
    swb_subber #(.W(8)) swb_subber_inst
    (
        .minuend(memRdData),
        .subtrahend(acc_q),
        .carryIn(flags_q[`SWB_FLAG_C]),
        .diff(diff),
        .carryOut(carryOut),
        .halfCarry(halfCarry),
        .overflow(overflow)
    );

    // Flags computed once, committed in the write phase
    // A zero result keeps the borrow flag set, even for 00h-FFh-1
    assign newFlags[`SWB_FLAG_C] = carryOut || (diff == 8'h00);
    assign newFlags[`SWB_FLAG_DC] = halfCarry;
    assign newFlags[`SWB_FLAG_Z] = (diff == 8'h00);
    assign newFlags[`SWB_FLAG_OV] = overflow;
    assign newFlags[`SWB_FLAG_N] = diff[7];

    // ======================================================
    // Phase sequencer: idle, read, process, write
    always_comb
    begin
        phase_d = phase_q;
        case (phase_q)
            swb_pkg::SWB_IDLE:
            begin
                if (start)
                begin
                    phase_d = swb_pkg::SWB_READ;
                end
            end
            swb_pkg::SWB_READ: phase_d = swb_pkg::SWB_PROC;
            swb_pkg::SWB_PROC: phase_d = swb_pkg::SWB_WRITE;
            swb_pkg::SWB_WRITE: phase_d = swb_pkg::SWB_IDLE;
            default: phase_d = swb_pkg::SWB_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_q <= swb_pkg::SWB_IDLE;
        end
        else
        begin
            phase_q <= phase_d;
        end
    end

    // Request capture; inputs may change once taken
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addr_q <= '0;
            opAddr_q <= 8'h00;
            target_q <= 1'b1;
            window_q <= 1'b0;
            ext_q <= 1'b0;
            bank_q <= '0;
        end
        else if (takeStart)
        begin
            addr_q <= operandFullAddr;
            opAddr_q <= operandAddr;
            target_q <= resultTarget;
            window_q <= windowSelect;
            ext_q <= extendedEnable;
            bank_q <= bankPointer;
        end
    end

    // Operand, result and pending flags latched in process phase
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            opnd_q <= 8'h00;
            result_q <= 8'h00;
            pend_q <= `SWB_FLAGS_RST;
        end
        else if (phase_q == swb_pkg::SWB_PROC)
        begin
            opnd_q <= memRdData;
            result_q <= diff;
            pend_q <= newFlags;
        end
    end

    // ======================================================
    // Destination write and architectural state
    assign commit = (phase_q == swb_pkg::SWB_WRITE);

    // Loads are refused while busy so the borrow read stays stable
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_q <= `SWB_ACC_RST;
        end
        else if (commit && !target_q)
        begin
            acc_q <= result_q;
        end
        else if (accLoad && (phase_q == swb_pkg::SWB_IDLE))
        begin
            acc_q <= accLoadValue;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flags_q <= `SWB_FLAGS_RST;
        end
        else if (commit)
        begin
            flags_q <= pend_q;
        end
        else if (flagsLoad && (phase_q == swb_pkg::SWB_IDLE))
        begin
            flags_q <= flagsLoadValue;
        end
    end

    // Memory port; write data is the latched result
    assign memAddr = addr_q;
    assign memRdEn = (phase_q == swb_pkg::SWB_READ);
    assign memWrEn = commit && target_q;
    assign memWrData = result_q;
    assign accumulator = acc_q;
    assign flags = flags_q;
    assign busy = (phase_q != swb_pkg::SWB_IDLE);
    assign done = commit;

    // ======================================================
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence s_walk;
        (phase_q == swb_pkg::SWB_READ) ##1
        (phase_q == swb_pkg::SWB_PROC) ##1
        (phase_q == swb_pkg::SWB_WRITE) ##1
        (phase_q == swb_pkg::SWB_IDLE);
    endsequence

    sequence s_fetch;
        (phase_q == swb_pkg::SWB_PROC) ##1
        (phase_q == swb_pkg::SWB_WRITE);
    endsequence

    a_phase_walk: assert property
        (takeStart |=> s_walk)
        else $error("phase walk broken");

    a_result_value: assert property
        (commit |-> result_q == 8'(opnd_q - acc_q
            - {7'h00, !flags_q[`SWB_FLAG_C]}))
        else $error("wrong difference");

    a_dest_acc: assert property
        (s_fetch ##0 !target_q |-> !memWrEn
            ##1 acc_q == $past(result_q))
        else $error("accumulator target wrong");

    a_dest_mem: assert property
        ((commit && target_q) |-> memWrEn && memWrData == 8'(opnd_q
            - acc_q - {7'h00, !flags_q[`SWB_FLAG_C]})
            ##1 acc_q == $past(acc_q))
        else $error("memory target wrong");

    a_access_bank: assert property
        ((memRdEn && !window_q && !(ext_q && opAddr_q <= 8'h5F))
            |-> memAddr[11:8] == ((opAddr_q <= 8'h5F) ? 4'h0 : 4'hF)
            && memAddr[7:0] == opAddr_q)
        else $error("access bank address wrong");

    a_bank_ptr: assert property
        ((memRdEn && window_q) |-> memAddr == {bank_q, opAddr_q})
        else $error("banked address wrong");

    a_indexed_mode: assert property
        ((takeStart && !windowSelect && extendedEnable
            && operandAddr <= 8'h5F)
            |=> memRdEn && memAddr == $past(indexBase)
            + {4'h0, $past(operandAddr)})
        else $error("indexed address wrong");

    a_zero_flag: assert property
        (commit |=> flags_q[`SWB_FLAG_Z] == ($past(result_q) == 8'h00)
            && (!flags_q[`SWB_FLAG_Z] || flags_q[`SWB_FLAG_C]))
        else $error("zero flag wrong");

    a_top_bit: assert property
        (commit |=> flags_q[`SWB_FLAG_N] == $past(result_q[7]))
        else $error("top bit flag wrong");

    a_wrap_flag: assert property
        (commit |=> flags_q[`SWB_FLAG_OV] ==
            ($past(opnd_q[7] ^ acc_q[7])
            && $past(opnd_q[7] ^ result_q[7])))
        else $error("signed wrap flag wrong");

endmodule

// ==== verif/swb_exec_test.sv ====
`include "swb_cfg.svh"

module swb_exec_test;
    timeunit 1ns;
    timeprecision 100ps;

    // ======================================================
    // Stimulus and observed signals
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic start = 1'b0;
    logic [7:0] operandAddr = 8'h00;
    logic resultTarget = 1'b0;
    logic windowSelect = 1'b0;
    logic extendedEnable = 1'b0;
    logic [3:0] bankPointer = 4'h0;
    logic [11:0] indexBase = 12'h000;
    logic accLoad = 1'b0;
    logic [7:0] accLoadValue = 8'h00;
    logic flagsLoad = 1'b0;
    logic [4:0] flagsLoadValue = 5'h00;
    logic [7:0] memRdData = 8'h00;
    logic [11:0] memAddr;
    logic memRdEn;
    logic memWrEn;
    logic [7:0] memWrData;
    logic [7:0] accumulator;
    logic [4:0] flags;
    logic busy;
    logic done;
    int mismatches = 0;
    int compares = 0;
    logic [7:0] accMdl = 8'h00;
    logic [4:0] flgMdl = 5'h00;

    swb_exec swb_exec_inst
    (
        .mclk(mclk), .arst_n(arst_n), .start(start),
        .operandAddr(operandAddr), .resultTarget(resultTarget),
        .windowSelect(windowSelect), .extendedEnable(extendedEnable),
        .bankPointer(bankPointer), .indexBase(indexBase),
        .accLoad(accLoad), .accLoadValue(accLoadValue),
        .flagsLoad(flagsLoad), .flagsLoadValue(flagsLoadValue),
        .memRdData(memRdData), .memAddr(memAddr), .memRdEn(memRdEn),
        .memWrEn(memWrEn), .memWrData(memWrData),
        .accumulator(accumulator), .flags(flags), .busy(busy),
        .done(done)
    );

    // ======================================================
    // Clock, 5 ns period
    always #2.5 mclk = ~mclk;

    // ======================================================
    // Compare tasks and verdict
    task automatic chkVal(input string name, input logic [11:0] exp,
        input logic [11:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chkBit(input string name, input logic exp,
        input logic got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic results();
        if (mismatches == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ======================================================
    // Load accumulator and borrow flag while idle
    task automatic loadRegs(input logic [7:0] w, input logic c);
        @(negedge mclk);
        accLoad = 1'b1;
        accLoadValue = w;
        flagsLoad = 1'b1;
        flagsLoadValue = {4'h0, c};
        @(negedge mclk);
        accLoad = 1'b0;
        flagsLoad = 1'b0;
        accMdl = w;
        flgMdl = {4'h0, c};
        chkVal("acc load", {4'h0, accMdl}, {4'h0, accumulator});
        chkVal("flags load", {7'h00, flgMdl}, {7'h00, flags});
    endtask

    // ======================================================
    // One instruction; probe tries loads while busy, which must be lost
    task automatic exec(input logic [7:0] fAddr, input logic tgt,
        input logic win, input logic ext, input logic [3:0] bank,
        input logic [11:0] base, input logic [11:0] expAddr,
        input logic [7:0] op, input logic probe);
        logic [8:0] sum;
        logic [4:0] half;
        logic [4:0] expFlg;
        // Borrow is the inverted carry, so add the complement plus carry
        sum = {1'b0, op} + {1'b0, ~accMdl} + {8'h00, flgMdl[`SWB_FLAG_C]};
        half = {1'b0, op[3:0]} + {1'b0, ~accMdl[3:0]}
            + {4'h0, flgMdl[`SWB_FLAG_C]};
        expFlg = 5'h00;
        expFlg[`SWB_FLAG_C] = sum[8] | (sum[7:0] == 8'h00);
        expFlg[`SWB_FLAG_DC] = half[4];
        expFlg[`SWB_FLAG_Z] = (sum[7:0] == 8'h00);
        expFlg[`SWB_FLAG_OV] = (op[7] ^ accMdl[7]) & (op[7] ^ sum[7]);
        expFlg[`SWB_FLAG_N] = sum[7];
        @(negedge mclk);
        operandAddr = fAddr;
        resultTarget = tgt;
        windowSelect = win;
        extendedEnable = ext;
        bankPointer = bank;
        indexBase = base;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        memRdData = op;
        chkBit("busy c1", 1'b1, busy);
        chkBit("memRdEn c1", 1'b1, memRdEn);
        chkVal("memAddr", expAddr, memAddr);
        if (probe)
        begin
            accLoad = 1'b1;
            accLoadValue = 8'hA5;
            flagsLoad = 1'b1;
            flagsLoadValue = 5'h1F;
        end
        @(negedge mclk);
        accLoad = 1'b0;
        flagsLoad = 1'b0;
        chkBit("memRdEn c2", 1'b0, memRdEn);
        chkBit("done c2", 1'b0, done);
        @(negedge mclk);
        // Read data no longer valid: show a changed value
        memRdData = ~op;
        chkBit("done c3", 1'b1, done);
        chkBit("memWrEn", tgt, memWrEn);
        chkVal("memWrData", {4'h0, sum[7:0]}, {4'h0, memWrData});
        if (!tgt)
            accMdl = sum[7:0];
        flgMdl = expFlg;
        @(negedge mclk);
        chkBit("busy c4", 1'b0, busy);
        chkVal("accumulator", {4'h0, accMdl}, {4'h0, accumulator});
        chkVal("flags", {7'h00, flgMdl}, {7'h00, flags});
    endtask

    // ======================================================
    // Watchdog, far beyond the roughly fifty cycles the tests need
    initial
    begin
        #(2000 * 5);
        mismatches++;
        results();
    end

    // ======================================================
    // Test sequence
    initial
    begin
        repeat (4) @(negedge mclk);
        arst_n = 1'b1;
        chkVal("acc reset", 12'h000, {4'h0, accumulator});
        chkVal("flags reset", 12'h000, {7'h00, flags});
        chkBit("busy reset", 1'b0, busy);
        loadRegs(8'h0D, 1'b1);
        exec(8'h20, 1'b1, 1'b0, 1'b0, 4'h7, 12'h000, 12'h020, 8'h19,
            1'b0);
        loadRegs(8'h1A, 1'b0);
        exec(8'h10, 1'b0, 1'b1, 1'b0, 4'h3, 12'h000, 12'h310, 8'h1B,
            1'b0);
        loadRegs(8'h0E, 1'b1);
        exec(8'h5F, 1'b1, 1'b0, 1'b1, 4'h2, 12'h100, 12'h15F, 8'h03,
            1'b1);
        loadRegs(8'h01, 1'b1);
        exec(8'h60, 1'b0, 1'b0, 1'b1, 4'h2, 12'h100, 12'hF60, 8'h80,
            1'b0);
        exec(8'h5F, 1'b0, 1'b0, 1'b0, 4'h9, 12'h100, 12'h05F, 8'h5F,
            1'b0);
        loadRegs(8'hFF, 1'b0);
        exec(8'h20, 1'b0, 1'b0, 1'b1, 4'h5, 12'hFF0, 12'h010, 8'h00,
            1'b0);
        exec(8'h10, 1'b1, 1'b1, 1'b1, 4'hA, 12'h100, 12'hA10, 8'h42,
            1'b0);
        results();
    end
endmodule
